//--- hw/obcd_defs.vh
// Constants for the option byte configuration decoder.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef OBCD_DEFS_VH
`define OBCD_DEFS_VH

// ********************************************************************
// Non-volatile option storage
// ********************************************************************
`define OBCD_BLANK_BYTE       8'hff
`define OBCD_ERASED_BYTE      8'h00
`define OBCD_RSVD_ONES        8'hfc
`define OBCD_SEL_BYTE0        1'b0
`define OBCD_SEL_BYTE1        1'b1

// ********************************************************************
// Option byte 0 fields
// ********************************************************************
`define OBCD_B0_AMP3_BIT      1
`define OBCD_B0_PROTECT_BIT   0

// ********************************************************************
// Option byte 1 fields
// ********************************************************************
`define OBCD_B1_CFOFF_BIT     7
`define OBCD_B1_OSC_HI        6
`define OBCD_B1_OSC_LO        4
`define OBCD_B1_LVT_HI        3
`define OBCD_B1_LVT_LO        2
`define OBCD_B1_WDHALT_BIT    1
`define OBCD_B1_WDSW_BIT      0

// ********************************************************************
// Oscillator and detector codes
// ********************************************************************
`define OBCD_OSC_EXT_CLOCK    3'h7
`define OBCD_OSC_INT_RC       3'h6
`define OBCD_OSC_EXT_RC_HI2   2'h2
`define OBCD_OSC_LOW_POWER    3'h3
`define OBCD_OSC_MED_POWER    3'h2
`define OBCD_OSC_MED_SPEED    3'h1
`define OBCD_OSC_HIGH_SPEED   3'h0
`define OBCD_LVT_OFF          2'h3

// ********************************************************************
// APB register map
// ********************************************************************
`define OBCD_ADDR_W           12
`define OBCD_OFS_CTRL         12'h000
`define OBCD_OFS_STATUS       12'h004
`define OBCD_CTRL_WDEN_BIT    0
`define OBCD_CTRL_RESET       32'h0000_0000

`endif

//--- hw/obcd_store.v
// Two option bytes held as non-volatile flip-flops, written by the
// external programmer. Assumes the caller only asserts wr_en while in
// programming mode; init_n models the blank state of a new part.
`timescale 1ns/1ps
`default_nettype none
`include "obcd_defs.vh"

module obcd_store (
    input  wire       pclk,
    input  wire       init_n,
    input  wire       wr_en,
    input  wire       wr_sel,
    input  wire [7:0] wr_data,
    output reg  [7:0] opt_byte0,
    output reg  [7:0] opt_byte1,
    output reg        erase_pulse
);

    // Clearing the protect bit while it is set wipes both bytes.
    wire clears_protect;
    assign clears_protect = wr_en && (wr_sel == `OBCD_SEL_BYTE0)
        && opt_byte0[`OBCD_B0_PROTECT_BIT]
        && !wr_data[`OBCD_B0_PROTECT_BIT];

    // ****************************************************************
    // Storage update
    // ****************************************************************
    // Kept off the system reset on purpose: a part reset must not lose
    // its programming, only a blank init restores the shipped state.
    always @(posedge pclk or negedge init_n) begin
        if (!init_n) begin
            opt_byte0   <= `OBCD_BLANK_BYTE;
            opt_byte1   <= `OBCD_BLANK_BYTE;
            erase_pulse <= 1'b0;
        end else begin
            erase_pulse <= clears_protect;
            if (clears_protect) begin
                opt_byte0 <= `OBCD_ERASED_BYTE;
                opt_byte1 <= `OBCD_ERASED_BYTE;
            end else if (wr_en && wr_sel == `OBCD_SEL_BYTE0) begin
                // Reserved upper bits are forced high on every write.
                opt_byte0 <= wr_data | `OBCD_RSVD_ONES;
            end else if (wr_en) begin
                opt_byte1 <= wr_data;
            end
        end
    end

endmodule
`default_nettype wire

//--- hw/obcd_top.v
// Option byte configuration decoder with APB status and control.
// Assumes one 25 MHz clock pclk, an APB master on that clock, and an
// external programmer driving the prog_* pins asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "obcd_defs.vh"

// Contract
// - The option bytes are never visible on the processor bus; only the programmer in programming mode reads or writes them.
// - Blank option storage reads as all ones in every byte.
// - Byte 0 bit 1 enables the third amplifier when one, and reserved upper bits are set to one on each write but cleared to zero by an erase.
// - Byte 0 bit 0 at one blocks read-out, and clearing it erases all memory to zeros.
// - Byte 1 bit 7 at zero enables the clock filter and at one disables it.
// - Byte 1 bits 6 to 4 select the main oscillator from the seven documented codes.
// - Byte 1 bits 3 to 2 set the voltage detector off or to high, medium or low threshold.
// - Byte 1 bit 1 at one resets on halt entry with the watchdog running, at zero never.
// - Byte 1 bit 0 at zero forces the watchdog on, at one software must enable it.
module obcd_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        blank_init_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        prog_mode,
    input  wire        prog_write,
    input  wire        prog_sel,
    input  wire [7:0]  prog_wdata,
    output reg  [7:0]  prog_rdata,
    output reg         memory_erase,
    input  wire        halt_entry,
    output reg         halt_reset_req,
    output reg         third_amp_enable,
    output reg         readout_protect,
    output reg         clock_filter_off,
    output reg  [2:0]  oscillator_select,
    output reg         osc_external_clock,
    output reg         osc_internal_rc,
    output reg         osc_external_rc,
    output reg         osc_resonator,
    output reg         low_voltage_detector,
    output reg  [1:0]  low_voltage_threshold_select,
    output reg         watchdog_reset_on_halt,
    output reg         watchdog_software_mode,
    output reg         watchdog_enable,
    output reg         config_loaded
);

    // ****************************************************************
    // Programmer pin synchronisers
    // ****************************************************************
    // Every programmer pin crosses in through three stages; a bit is
    // accepted only once the second and third stages agree, so select
    // and data are never caught half way through a change.
    reg  [10:0] pin_s1;
    reg  [10:0] pin_s2;
    reg  [10:0] pin_s3;
    reg  [10:0] pin_filt;
    reg         write_seen;
    wire        prog_mode_f;
    wire        prog_write_f;
    wire        prog_sel_f;
    wire [7:0]  prog_wdata_f;
    wire        prog_write_rise;

    assign prog_mode_f     = pin_filt[10];
    assign prog_write_f    = pin_filt[9];
    assign prog_sel_f      = pin_filt[8];
    assign prog_wdata_f    = pin_filt[7:0];
    // Writes outside programming mode are dropped, so software or a
    // stray pin can never alter the options.
    assign prog_write_rise = prog_write_f && !write_seen && prog_mode_f;

    // Synchroniser and glitch filter stages.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1     <= 11'h000;
            pin_s2     <= 11'h000;
            pin_s3     <= 11'h000;
            pin_filt   <= 11'h000;
            write_seen <= 1'b0;
        end else begin
            pin_s1     <= {prog_mode, prog_write, prog_sel, prog_wdata};
            pin_s2     <= pin_s1;
            pin_s3     <= pin_s2;
            // Per bit: agreeing stages are taken, a disagreeing bit holds.
            pin_filt   <= (pin_s2 & pin_s3) | (pin_filt & (pin_s2 | pin_s3));
            write_seen <= prog_write_f;
        end
    end

    // ****************************************************************
    // Option storage
    // ****************************************************************
    wire [7:0] opt_byte0;
    wire [7:0] opt_byte1;
    wire       erase_now;

    obcd_store u_store (
        .pclk        (pclk),
        .init_n      (blank_init_n),
        .wr_en       (prog_write_rise),
        .wr_sel      (prog_sel_f),
        .wr_data     (prog_wdata_f),
        .opt_byte0   (opt_byte0),
        .opt_byte1   (opt_byte1),
        .erase_pulse (erase_now)
    );

    // Programmer read-back and erase strobe to the program memory.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_rdata   <= 8'h00;
            memory_erase <= 1'b0;
        end else begin
            memory_erase <= erase_now;
            if (!prog_mode_f) begin
                prog_rdata <= 8'h00;
            end else if (prog_sel_f == `OBCD_SEL_BYTE0) begin
                prog_rdata <= opt_byte0;
            end else begin
                prog_rdata <= opt_byte1;
            end
        end
    end

    // ****************************************************************
    // Capture of decoded settings
    // ****************************************************************
    // One capture right after reset release; later programming has no
    // effect until the next reset, which keeps the clock tree stable.
    wire [2:0] osc_code;
    assign osc_code = opt_byte1[`OBCD_B1_OSC_HI:`OBCD_B1_OSC_LO];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_loaded                <= 1'b0;
            third_amp_enable             <= 1'b0;
            readout_protect              <= 1'b1;
            clock_filter_off             <= 1'b1;
            oscillator_select            <= `OBCD_OSC_EXT_CLOCK;
            osc_external_clock           <= 1'b0;
            osc_internal_rc              <= 1'b0;
            osc_external_rc              <= 1'b0;
            osc_resonator                <= 1'b0;
            low_voltage_detector         <= 1'b0;
            low_voltage_threshold_select <= `OBCD_LVT_OFF;
            watchdog_reset_on_halt       <= 1'b0;
            watchdog_software_mode       <= 1'b1;
        end else if (!config_loaded) begin
            config_loaded    <= 1'b1;
            third_amp_enable <= opt_byte0[`OBCD_B0_AMP3_BIT];
            readout_protect  <= opt_byte0[`OBCD_B0_PROTECT_BIT];
            clock_filter_off <= opt_byte1[`OBCD_B1_CFOFF_BIT];
            oscillator_select  <= osc_code;
            osc_external_clock <= (osc_code == `OBCD_OSC_EXT_CLOCK);
            osc_internal_rc    <= (osc_code == `OBCD_OSC_INT_RC);
            osc_external_rc    <=
                (osc_code[2:1] == `OBCD_OSC_EXT_RC_HI2);
            osc_resonator      <= !osc_code[2];
            low_voltage_detector <=
                (opt_byte1[`OBCD_B1_LVT_HI:`OBCD_B1_LVT_LO]
                 != `OBCD_LVT_OFF);
            low_voltage_threshold_select <=
                opt_byte1[`OBCD_B1_LVT_HI:`OBCD_B1_LVT_LO];
            watchdog_reset_on_halt <= opt_byte1[`OBCD_B1_WDHALT_BIT];
            watchdog_software_mode <= opt_byte1[`OBCD_B1_WDSW_BIT];
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // One wait state: pready is raised at the end of the first access cycle and
    // the transfer completes on the next edge. Registered outputs cost
    // a cycle but keep every bus output straight from a flip-flop.
    reg        sw_watchdog_en;
    wire       apb_done;
    wire [31:0] status_word;

    assign apb_done    = psel && penable && pready;
    // Decoded settings and status flags are visible; raw option bytes never are.
    assign status_word = {13'h0000, prog_mode_f, config_loaded,
                          watchdog_enable, watchdog_software_mode,
                          watchdog_reset_on_halt,
                          low_voltage_threshold_select,
                          low_voltage_detector, oscillator_select,
                          clock_filter_off, readout_protect,
                          third_amp_enable, 5'h00};

    // Bus handshake, decode and read data.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            if (paddr == `OBCD_OFS_CTRL) begin
                pslverr <= 1'b0;
                prdata  <= pwrite ? 32'h0000_0000
                         : {31'h0000_0000, sw_watchdog_en};
            end else if (paddr == `OBCD_OFS_STATUS) begin
                pslverr <= pwrite;
                prdata  <= pwrite ? 32'h0000_0000 : status_word;
            end else begin
                pslverr <= 1'b1;
                prdata  <= 32'h0000_0000;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Software enable of the watchdog; once on it stays on to reset,
    // so a runaway program cannot switch its own supervisor off.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_watchdog_en <= 1'b0;
        end else if (apb_done && pwrite && paddr == `OBCD_OFS_CTRL
                     && pwdata[`OBCD_CTRL_WDEN_BIT]) begin
            sw_watchdog_en <= 1'b1;
        end
    end

    // ****************************************************************
    // Watchdog enable and halt reset
    // ****************************************************************
    // Hardware mode forces the watchdog on from the cycle after the capture onward.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_enable <= 1'b0;
            halt_reset_req  <= 1'b0;
        end else begin
            watchdog_enable <= config_loaded
                && (!watchdog_software_mode || sw_watchdog_en);
            halt_reset_req  <= halt_entry && watchdog_enable
                && watchdog_reset_on_halt;
        end
    end

endmodule
`default_nettype wire

//--- dv/obcd_chk.sv
// Concurrent checks on the ports of the option byte decoder.
// Assumes it is bound to obcd_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module obcd_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       prog_mode,
    input wire logic [7:0] prog_rdata,
    input wire logic       memory_erase,
    input wire logic       halt_entry,
    input wire logic       halt_reset_req,
    input wire logic       third_amp_enable,
    input wire logic [2:0] oscillator_select,
    input wire logic       osc_external_clock,
    input wire logic       osc_internal_rc,
    input wire logic       osc_external_rc,
    input wire logic       osc_resonator,
    input wire logic       low_voltage_detector,
    input wire logic [1:0] low_voltage_threshold_select,
    input wire logic       watchdog_reset_on_halt,
    input wire logic       watchdog_software_mode,
    input wire logic       watchdog_enable,
    input wire logic       config_loaded
);
    // One clock domain, so clock and reset are shared by every check.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_armed;
        halt_entry && watchdog_enable && watchdog_reset_on_halt;
    endsequence
    // Eight low samples outlast the pin filter and the read register.
    sequence s_mode_off;
        !prog_mode [*8];
    endsequence
    property p_halt;
        s_armed |=> halt_reset_req;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt reset request missing");
    property p_halt_cause;
        halt_reset_req |-> $past(halt_entry) && $past(watchdog_enable)
            && $past(watchdog_reset_on_halt);
    endproperty
    a_halt_cause: assert property (p_halt_cause)
        else $error("halt reset request without cause");
    property p_hold;
        config_loaded && $past(config_loaded) |-> $stable(oscillator_select)
            && $stable(third_amp_enable)
            && $stable(low_voltage_threshold_select);
    endproperty
    a_hold: assert property (p_hold)
        else $error("settings changed between resets");
    property p_ext_clk;
        config_loaded |-> osc_external_clock == (oscillator_select == 3'h7);
    endproperty
    a_ext_clk: assert property (p_ext_clk)
        else $error("external clock flag wrong");
    property p_int_rc;
        config_loaded |-> osc_internal_rc == (oscillator_select == 3'h6);
    endproperty
    a_int_rc: assert property (p_int_rc)
        else $error("internal oscillator flag wrong");
    property p_osc_kind;
        config_loaded |-> osc_external_rc == (oscillator_select[2:1] == 2'h2)
            && osc_resonator == !oscillator_select[2];
    endproperty
    a_osc_kind: assert property (p_osc_kind)
        else $error("oscillator kind flags wrong");
    property p_lvd;
        config_loaded |->
            low_voltage_detector == (low_voltage_threshold_select != 2'h3);
    endproperty
    a_lvd: assert property (p_lvd)
        else $error("voltage detector enable wrong");
    property p_wd_hw;
        config_loaded && !watchdog_software_mode |=> watchdog_enable;
    endproperty
    a_wd_hw: assert property (p_wd_hw)
        else $error("hardware watchdog not running");
    property p_hidden;
        s_mode_off |-> prog_rdata == 8'h00;
    endproperty
    a_hidden: assert property (p_hidden)
        else $error("option bytes visible outside programming");
    property p_erase;
        memory_erase |-> prog_mode ##1 !memory_erase;
    endproperty
    a_erase: assert property (p_erase)
        else $error("erase pulse malformed or outside programming");
endmodule
`default_nettype wire

//--- dv/obcd_prog_model.sv
// Behavioural external programmer driving the option byte pins.
// Assumes the bench calls its tasks one at a time on pclk.
`timescale 1ns/1ps
`default_nettype none
module obcd_prog_model (
    input  wire logic       pclk,
    output var  logic       prog_mode,
    output var  logic       prog_write,
    output var  logic       prog_sel,
    output var  logic [7:0] prog_wdata
);
    initial begin
        prog_mode = 1'b0;
        prog_write = 1'b0;
        prog_sel = 1'b0;
        prog_wdata = 8'h00;
    end
    // Pins settle well before the strobe, since the device filters them.
    task automatic write_byte(input logic mode, input logic sel,
                              input logic [7:0] data);
        @(posedge pclk);
        prog_mode <= mode;
        prog_sel <= sel;
        prog_wdata <= data;
        repeat (6) @(posedge pclk);
        prog_write <= 1'b1;
        repeat (6) @(posedge pclk);
        prog_write <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    // Data is no longer held, so it shows the inverse of the last value.
    task automatic leave_mode;
        @(posedge pclk);
        prog_mode <= 1'b0;
        prog_wdata <= ~prog_wdata;
        repeat (8) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

//--- dv/option_byte_config_decode_bench.sv
// Self-checking bench for the option byte decoder over APB and pins.
// Assumes obcd_top, obcd_prog_model and obcd_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decode_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        blank_init_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        halt_entry = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, memory_erase, halt_reset_req;
    wire         prog_mode, prog_write, prog_sel;
    wire  [7:0]  prog_wdata, prog_rdata;
    wire  [2:0]  oscillator_select;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  b1;
    logic [2:0]  osc, k;
    int          bad_count = 0;
    int          comparisons = 0;
    int          erase_count = 0;

    always #20 pclk = ~pclk;
    obcd_top dut (.pclk, .presetn, .blank_init_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_mode,
        .prog_write, .prog_sel, .prog_wdata, .prog_rdata, .memory_erase,
        .halt_entry, .halt_reset_req, .third_amp_enable(),
        .readout_protect(), .clock_filter_off(), .oscillator_select,
        .osc_external_clock(), .osc_internal_rc(), .osc_external_rc(),
        .osc_resonator(), .low_voltage_detector(),
        .low_voltage_threshold_select(), .watchdog_reset_on_halt(),
        .watchdog_software_mode(), .watchdog_enable(), .config_loaded());
    obcd_prog_model prog (.pclk, .prog_mode, .prog_write, .prog_sel,
        .prog_wdata);
    // Erase pulses are counted so a refused write can be seen to do nothing.
    always @(posedge pclk) if (memory_erase === 1'b1) erase_count++;

    // Status word as the decoded option bytes should present it.
    function automatic logic [31:0] exp_status(input logic [7:0] b0,
        input logic [7:0] b, input logic wden);
        exp_status = 32'h0002_0000;
        exp_status[15:5] = {b[0], b[1], b[3:2], b[3:2] != 2'h3, b[6:4],
                            b[7], b0[0], b0[1]};
        exp_status[16] = wden | !b[0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 2, "one wait state");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic halt_pulse;
        @(posedge pclk);
        halt_entry <= 1'b1;
        @(posedge pclk);
        halt_entry <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        blank_init_n <= 1'b1;
        apb(0, 12'h004, 0);
        chk(rd, exp_status(8'hff, 8'hff, 0), "blank status");
        apb(0, 12'h000, 0);
        chk(rd, 0, "control reset value");
        halt_pulse;
        chk(halt_reset_req, 0, "halt with watchdog off");
        apb(1, 12'h000, 1);
        apb(0, 12'h004, 0);
        chk(rd, exp_status(8'hff, 8'hff, 1), "software enable");
        halt_pulse;
        chk(halt_reset_req, 1, "halt with watchdog on");
        apb(0, 12'h008, 0);
        chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
        apb(1, 12'h004, 32'hffff_ffff);
        chk(er, 1, "status write refused");
        $display("test registers done");
        prog.write_byte(0, 0, 8'h00);
        prog.leave_mode;
        chk(erase_count, 0, "write outside programming");
        prog.write_byte(1, 0, 8'h01);
        chk(prog_rdata, 8'hfd, "reserved bits kept");
        apb(0, 12'h004, 0);
        chk(rd ^ 32'h0004_0000, exp_status(8'hff, 8'hff, 1), "mode");
        prog.leave_mode;
        prog.write_byte(1, 0, 8'h02);
        chk(prog_rdata, 8'h00, "erased byte");
        chk(erase_count, 1, "one erase");
        prog.leave_mode;
        prog.write_byte(1, 0, 8'h02);
        chk(prog_rdata, 8'hfe, "amplifier on, unprotected");
        chk(erase_count, 1, "no erase when already clear");
        prog.leave_mode;
        $display("test option bytes done");
        osc = 3'h7;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            b1 = {k[0], k, k[1:0], k[1], k[2]};
            prog.write_byte(1, 1, b1);
            chk(prog_rdata, b1, "byte readback");
            prog.leave_mode;
            chk(oscillator_select, osc, "held until reset");
            do_reset;
            apb(0, 12'h004, 0);
            chk(rd, exp_status(8'hfe, b1, 0), "decode");
            osc = b1[6:4];
        end
        $display("test decode done");
        print_verdict;
    end
    // The run needs under 1000 cycles; this cuts a hang short.
    initial begin
        #80000;
        chk(0, 1, "timeout");
        print_verdict;
    end
endmodule
bind obcd_top obcd_chk u_chk (.pclk, .presetn, .prog_mode, .prog_rdata,
    .memory_erase, .halt_entry, .halt_reset_req, .third_amp_enable,
    .oscillator_select, .osc_external_clock, .osc_internal_rc,
    .osc_external_rc,
    .osc_resonator, .low_voltage_detector, .low_voltage_threshold_select,
    .watchdog_reset_on_halt, .watchdog_software_mode, .watchdog_enable,
    .config_loaded);
`default_nettype wire
